// [rtl/srr_pkg.sv]
// constants for the sensor result readout register group
package srr_pkg;

  // ---------------------------------------------------------------
  // register addresses (command byte pointer)
  // ---------------------------------------------------------------
  localparam int PTR_W = 5;
  localparam logic [4:0] ADDR_REVISION = 5'h11;
  localparam logic [4:0] ADDR_PART_ID = 5'h12;
  localparam logic [4:0] ADDR_FLAGS = 5'h13;
  localparam logic [4:0] ADDR_CH0_LOW = 5'h14;
  localparam logic [4:0] ADDR_CH0_HIGH = 5'h15;
  localparam logic [4:0] ADDR_CH1_LOW = 5'h16;
  localparam logic [4:0] ADDR_CH1_HIGH = 5'h17;
  localparam logic [4:0] ADDR_NEAR_LOW = 5'h18;
  localparam logic [4:0] ADDR_NEAR_HIGH = 5'h19;
  localparam int NUM_RESULTS = 3;

  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int FLAG_NEAR_IRQ = 5;
  localparam int FLAG_LIGHT_IRQ = 4;
  localparam int FLAG_NEAR_READY = 1;
  localparam int FLAG_LIGHT_READY = 0;

  // ---------------------------------------------------------------
  // identity values (arbitrary, neutral) and bus address
  // ---------------------------------------------------------------
  localparam logic [7:0] REVISION_VALUE = 8'h5A; // arbitrary value
  localparam logic [7:0] PART_ID_VALUE = 8'hC3; // arbitrary value
  localparam logic [6:0] BUS_ADDRESS = 7'h4A; // arbitrary value

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_MACK = 3'b100
  } srr_state_t;

  // meaning of the byte being received
  typedef enum logic [1:0] {
    KIND_ADDR = 2'b00,
    KIND_CMD = 2'b01,
    KIND_DATA = 2'b10
  } srr_kind_t;

endpackage

// [rtl/srr_readout.sv]
// serial slave serving the identification, status and result registers
`timescale 1ns/1ps

module srr_readout
  import srr_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [15:0] light_ch0_data,
  input wire logic [15:0] light_ch1_data,
  input wire logic [15:0] near_object_data,
  input wire logic near_object_irq_flag,
  input wire logic light_irq_flag,
  input wire logic near_object_result_ready,
  input wire logic light_result_ready
);

  // ---------------------------------------------------------------
  // pin synchronisers and bus events
  // ---------------------------------------------------------------
  logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  // two flops per pin, then a history flop for edge finding
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_i;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  // edges and start/stop conditions
  assign scl_rise = scl_sync_reg && !scl_prev_reg;
  assign scl_fall = !scl_sync_reg && scl_prev_reg;
  assign bus_start = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;
  assign bus_stop = scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg;

  // ---------------------------------------------------------------
  // serial engine
  // ---------------------------------------------------------------
  srr_state_t state_reg;
  srr_kind_t kind_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [PTR_W-1:0] ptr_reg;
  logic rw_reg;
  logic mack_reg;
  logic load_en;
  logic [7:0] read_byte;
  logic [7:0] flags_byte;
  logic [15:0] result [NUM_RESULTS];
  logic [7:0] shadow_reg [NUM_RESULTS];

  // a byte is fetched after a read address ack or a master ack
  assign load_en = scl_fall && ((state_reg == ST_ACK && rw_reg && kind_reg == KIND_ADDR) ||
                                (state_reg == ST_MACK && !mack_reg));

  // byte sequencing state machine
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      kind_reg <= KIND_ADDR;
      bit_cnt_reg <= 4'h0;
      rx_reg <= BYTE_RESET;
      rw_reg <= 1'b0;
      mack_reg <= 1'b1;
    end else if (bus_start) begin
      state_reg <= ST_RX;
      kind_reg <= KIND_ADDR;
      bit_cnt_reg <= 4'h0;
    end else if (bus_stop) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_RX: begin
          if (scl_rise && bit_cnt_reg != BITS_PER_BYTE) begin
            rx_reg <= {rx_reg[6:0], sda_sync_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
            if (kind_reg != KIND_ADDR || rx_reg[7:1] == BUS_ADDRESS) begin
              state_reg <= ST_ACK;
            end else begin
              state_reg <= ST_IDLE; // not our address
            end
            if (kind_reg == KIND_ADDR) begin
              rw_reg <= rx_reg[0];
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg && kind_reg == KIND_ADDR) begin
              state_reg <= ST_TX;
            end else begin
              state_reg <= ST_RX;
              kind_reg <= (kind_reg == KIND_ADDR) ? KIND_CMD : KIND_DATA;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == LAST_TX_BIT) begin
              state_reg <= ST_MACK;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_reg <= sda_sync_reg;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= mack_reg ? ST_IDLE : ST_TX;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // register pointer: set by the command byte, stepped per read byte;
  // data bytes of a write are acknowledged and dropped
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ptr_reg <= 5'h00;
    end else if (state_reg == ST_RX && kind_reg == KIND_CMD && scl_fall &&
                 bit_cnt_reg == BITS_PER_BYTE) begin
      ptr_reg <= rx_reg[PTR_W-1:0];
    end else if (load_en) begin
      ptr_reg <= ptr_reg + 5'h01;
    end
  end

  // transmit shifter, msb first
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_reg <= BYTE_RESET;
    end else if (load_en) begin
      tx_reg <= read_byte;
    end else if (state_reg == ST_TX && scl_fall && bit_cnt_reg != LAST_TX_BIT) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // open-drain drive: low for ack or for a zero data bit
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= (state_reg == ST_ACK) || (state_reg == ST_TX && !tx_reg[7]);
    end
  end
  assign sda_o = 1'b0;

  // ---------------------------------------------------------------
  // result shadows, one per 16-bit result
  // ---------------------------------------------------------------
  assign result[0] = light_ch0_data;
  assign result[1] = light_ch1_data;
  assign result[2] = near_object_data;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RESULTS; gi++) begin : g_shadow
      localparam logic [4:0] LOW_ADDR = ADDR_CH0_LOW + 5'(2 * gi);
      // only a low byte fetch reloads the shadow; writes never do
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          shadow_reg[gi] <= BYTE_RESET;
        end else if (load_en && ptr_reg == LOW_ADDR) begin
          shadow_reg[gi] <= result[gi][15:8];
        end
      end

      shadow_latch_a: assert property (@(posedge clock) disable iff (!arst_n)
        load_en && ptr_reg == LOW_ADDR |=> shadow_reg[gi] == $past(result[gi][15:8]))
        else $error("shadow not loaded on low byte fetch");
      low_byte_a: assert property (@(posedge clock) disable iff (!arst_n)
        load_en && ptr_reg == LOW_ADDR |=> tx_reg == $past(result[gi][7:0]))
        else $error("low byte fetch returned wrong data");
      high_shadow_a: assert property (@(posedge clock) disable iff (!arst_n)
        load_en && ptr_reg == LOW_ADDR + 5'h01 |=> tx_reg == $past(shadow_reg[gi]))
        else $error("high byte not served from shadow");
      shadow_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        !load_en |=> $stable(shadow_reg[gi]))
        else $error("shadow changed without a read fetch");
    end
  endgenerate

  // ---------------------------------------------------------------
  // read data selection
  // ---------------------------------------------------------------
  // status byte, reserved bits read as zero
  assign flags_byte = {2'b00, near_object_irq_flag, light_irq_flag,
                       2'b00, near_object_result_ready, light_result_ready};

  // address decode, high bytes answer from their shadow, unmapped reads give zero
  always_comb begin
    if (ptr_reg == ADDR_REVISION) begin
      read_byte = REVISION_VALUE;
    end else if (ptr_reg == ADDR_PART_ID) begin
      read_byte = PART_ID_VALUE;
    end else if (ptr_reg == ADDR_FLAGS) begin
      read_byte = flags_byte;
    end else if (ptr_reg == ADDR_CH0_LOW) begin
      read_byte = light_ch0_data[7:0];
    end else if (ptr_reg == ADDR_CH1_LOW) begin
      read_byte = light_ch1_data[7:0];
    end else if (ptr_reg == ADDR_NEAR_LOW) begin
      read_byte = near_object_data[7:0];
    end else if (ptr_reg == ADDR_CH0_HIGH) begin
      read_byte = shadow_reg[0];
    end else if (ptr_reg == ADDR_CH1_HIGH) begin
      read_byte = shadow_reg[1];
    end else if (ptr_reg == ADDR_NEAR_HIGH) begin
      read_byte = shadow_reg[2];
    end else begin
      read_byte = BYTE_RESET;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  revision_read_a: assert property (@(posedge clock) disable iff (!arst_n)
    load_en && ptr_reg == ADDR_REVISION |=> tx_reg == REVISION_VALUE)
    else $error("revision byte wrong");
  part_id_read_a: assert property (@(posedge clock) disable iff (!arst_n)
    load_en && ptr_reg == ADDR_PART_ID |=> tx_reg == PART_ID_VALUE)
    else $error("part code wrong");
  status_reserved_a: assert property (@(posedge clock) disable iff (!arst_n)
    load_en && ptr_reg == ADDR_FLAGS |=> tx_reg[7:6] == 2'b00 && tx_reg[3:2] == 2'b00)
    else $error("reserved status bits not zero");
  near_irq_bit_a: assert property (@(posedge clock) disable iff (!arst_n)
    load_en && ptr_reg == ADDR_FLAGS |=> tx_reg[FLAG_NEAR_IRQ] == $past(near_object_irq_flag))
    else $error("near-object interrupt bit wrong");
  light_irq_bit_a: assert property (@(posedge clock) disable iff (!arst_n)
    load_en && ptr_reg == ADDR_FLAGS |=> tx_reg[FLAG_LIGHT_IRQ] == $past(light_irq_flag))
    else $error("light interrupt bit wrong");
  near_ready_bit_a: assert property (@(posedge clock) disable iff (!arst_n)
    load_en && ptr_reg == ADDR_FLAGS |=>
      tx_reg[FLAG_NEAR_READY] == $past(near_object_result_ready))
    else $error("near-object ready bit wrong");
  light_ready_bit_a: assert property (@(posedge clock) disable iff (!arst_n)
    load_en && ptr_reg == ADDR_FLAGS |=>
      tx_reg[FLAG_LIGHT_READY] == $past(light_result_ready))
    else $error("light ready bit wrong");
  near_high_a: assert property (@(posedge clock) disable iff (!arst_n)
    load_en && ptr_reg == ADDR_NEAR_LOW |=> ptr_reg == ADDR_NEAR_HIGH)
    else $error("pointer did not step from near-object low to high byte");

  status_read_c: cover property (@(posedge clock) disable iff (!arst_n)
    load_en && ptr_reg == ADDR_FLAGS);
  word_read_c: cover property (@(posedge clock) disable iff (!arst_n)
    load_en && ptr_reg == ADDR_CH0_LOW ##[1:400] load_en && ptr_reg == ADDR_CH0_HIGH);
  write_data_c: cover property (@(posedge clock) disable iff (!arst_n)
    state_reg == ST_RX && kind_reg == KIND_DATA && scl_fall && bit_cnt_reg == BITS_PER_BYTE);

endmodule

// [bench/srr_host_model.sv]
// host side model: two-wire bus master making the link clock and data
`timescale 1ns/1ps

module srr_host_model
  import srr_pkg::*;
(
  input wire logic clock,
  output logic scl,
  output logic sda_low,
  input wire logic sda_wire
);
  // ---------------------------------------------------------------
  // link timing, 80 ns period in system clocks
  // ---------------------------------------------------------------
  localparam int LOW_CYC = 5;
  localparam int HIGH_CYC = 3;

  // bus idle, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // wait on falling system clock edges
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // one bit: data moves only while link clock is low, sampled late in high
  task automatic bit_xfer(input logic tx, output logic rx);
    scl = 1'b0;
    wait_cyc(1);
    sda_low = !tx;
    wait_cyc(LOW_CYC - 1);
    scl = 1'b1;
    wait_cyc(HIGH_CYC - 1);
    rx = sda_wire;
    wait_cyc(1);
  endtask

  // start (data falls) or stop (data rises) while link clock high
  task automatic cond(input logic is_start);
    scl = 1'b0;
    wait_cyc(1);
    sda_low = !is_start;
    wait_cyc(LOW_CYC - 1);
    scl = 1'b1;
    wait_cyc(HIGH_CYC);
    sda_low = is_start;
    wait_cyc(HIGH_CYC);
  endtask

  // byte out msb first, then sample the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
    bit_xfer(1'b1, nak);
  endtask

  // byte in msb first, then ack or nack
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, b[i]);
    bit_xfer(last, r);
  endtask

  // pointer set, repeated start, one or two bytes read
  task automatic read_regs(input logic [4:0] ptr, input logic two, output logic [7:0] lo,
                           output logic [7:0] hi, output logic nak);
    logic a0, a1, a2;
    cond(1'b1);
    send_byte({BUS_ADDRESS, 1'b0}, a0);
    send_byte({3'b101, ptr}, a1); // word-read command type
    cond(1'b1);
    send_byte({BUS_ADDRESS, 1'b1}, a2);
    recv_byte(!two, lo);
    hi = 8'h00;
    if (two) recv_byte(1'b1, hi);
    cond(1'b0);
    nak = a0 | a1 | a2;
  endtask

  // pointer set then one data byte; reserved flag bits always zero
  task automatic write_reg(input logic [4:0] ptr, input logic [7:0] d, output logic nak);
    logic a0, a1, a2;
    cond(1'b1);
    send_byte({BUS_ADDRESS, 1'b0}, a0);
    send_byte({3'b101, ptr}, a1);
    send_byte((ptr == ADDR_FLAGS) ? (d & 8'h33) : d, a2);
    cond(1'b0);
    nak = a0 | a1 | a2;
  endtask

  // address only, to see whether a slave answers
  task automatic probe(input logic [6:0] addr, output logic nak);
    cond(1'b1);
    send_byte({addr, 1'b0}, nak);
    cond(1'b0);
  endtask
endmodule

// [bench/srr_readout_tb.sv]
// self-checking bench for the sensor result readout register group
`timescale 1ns/1ps

module srr_readout_tb;
  import srr_pkg::*;

  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic scl, sda_low, sda_o, sda_oe, sda_wire;
  logic [15:0] light_ch0_data = 16'h0000;
  logic [15:0] light_ch1_data = 16'h0000;
  logic [15:0] near_object_data = 16'h0000;
  logic [3:0] flags = 4'h0;
  logic [15:0] val [3];
  int miscompares = 0;
  int n_checks = 0;

  // 100 MHz clock
  always #5 clock = ~clock;

  // open-drain wire with pull-up
  assign sda_wire = !sda_low && (!sda_oe || sda_o);

  srr_readout dut (.clock(clock), .arst_n(arst_n), .scl(scl), .sda_i(sda_wire),
    .sda_o(sda_o), .sda_oe(sda_oe), .light_ch0_data(light_ch0_data),
    .light_ch1_data(light_ch1_data), .near_object_data(near_object_data),
    .near_object_irq_flag(flags[3]), .light_irq_flag(flags[2]),
    .near_object_result_ready(flags[1]), .light_result_ready(flags[0]));

  srr_host_model host (.clock(clock), .scl(scl), .sda_low(sda_low), .sda_wire(sda_wire));

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // fixed bytes, write attempt, unmapped place, foreign address
  task automatic t_ident();
    logic [7:0] lo, hi;
    logic nak;
    host.read_regs(ADDR_REVISION, 1'b0, lo, hi, nak);
    chk("revision", REVISION_VALUE, lo);
    chk("ack", 8'h00, {7'h00, nak});
    host.read_regs(ADDR_PART_ID, 1'b0, lo, hi, nak);
    chk("part code", PART_ID_VALUE, lo);
    host.write_reg(ADDR_REVISION, ~REVISION_VALUE, nak);
    host.read_regs(ADDR_REVISION, 1'b1, lo, hi, nak);
    chk("revision after write", REVISION_VALUE, lo);
    chk("part code by increment", PART_ID_VALUE, hi);
    host.read_regs(5'h1A, 1'b0, lo, hi, nak);
    chk("unmapped", BYTE_RESET, lo);
    host.probe(BUS_ADDRESS ^ 7'h01, nak);
    chk("foreign nack", 8'h01, {7'h00, nak});
  endtask

  // every combination of the four flag inputs, then a write attempt
  task automatic t_flags();
    logic [7:0] lo, hi;
    logic nak;
    for (int i = 0; i < 16; i++) begin
      flags = 4'(i);
      host.read_regs(ADDR_FLAGS, 1'b0, lo, hi, nak);
      chk("flags", {2'b00, flags[3:2], 2'b00, flags[1:0]}, lo);
    end
    flags = 4'h0;
    host.write_reg(ADDR_FLAGS, 8'hFF, nak);
    host.read_regs(ADDR_FLAGS, 1'b0, lo, hi, nak);
    chk("flags after write", 8'h00, lo);
  endtask

  // word reads, then shadow held across new results and writes
  task automatic t_results();
    logic [7:0] lo, hi, hi2;
    logic [4:0] ptr;
    logic nak;
    val[0] = 16'hA1B2;
    val[1] = 16'hC3D4;
    val[2] = 16'hE5F6;
    for (int r = 0; r < NUM_RESULTS; r++) begin
      ptr = ADDR_CH0_LOW + 5'(2 * r);
      light_ch0_data = val[0];
      light_ch1_data = val[1];
      near_object_data = val[2];
      host.read_regs(ptr, 1'b1, lo, hi, nak);
      chk("result low", val[r][7:0], lo);
      chk("result high", val[r][15:8], hi);
      host.read_regs(ptr, 1'b0, lo, hi, nak);
      light_ch0_data = ~val[0];
      light_ch1_data = ~val[1];
      near_object_data = ~val[2];
      host.read_regs(ptr + 5'h01, 1'b0, hi, hi2, nak);
      chk("shadow after new result", val[r][15:8], hi);
      host.write_reg(ptr + 5'h01, 8'h00, nak);
      host.write_reg(ptr, 8'h00, nak);
      host.read_regs(ptr + 5'h01, 1'b0, hi, hi2, nak);
      chk("shadow after write", val[r][15:8], hi);
      host.read_regs(ptr, 1'b1, lo, hi, nak);
      chk("new high", ~val[r][15:8], hi);
    end
  endtask

  // mid-run reset: data pin released, channel 1 shadow cleared
  task automatic t_reset();
    logic [7:0] lo, hi;
    logic nak;
    arst_n = 1'b0;
    repeat (3) @(negedge clock);
    chk("sda_oe in reset", 8'h00, {7'h00, sda_oe});
    chk("sda_o", 8'h00, {7'h00, sda_o});
    arst_n = 1'b1;
    @(negedge clock);
    chk("sda_oe after reset", 8'h00, {7'h00, sda_oe});
    repeat (4) @(negedge clock);
    host.read_regs(ADDR_CH1_HIGH, 1'b0, lo, hi, nak);
    chk("shadow after reset", BYTE_RESET, lo);
    chk("ack after reset", 8'h00, {7'h00, nak});
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clock);
    arst_n = 1'b1;
    repeat (5) @(negedge clock);
    t_ident();
    t_flags();
    t_results();
    t_reset();
    end_of_test();
  end

  // about 14.4k cycles expected; cut off at 40k cycles
  initial begin
    #400000;
    miscompares++;
    $display("Error watchdog expected finish seen timeout");
    end_of_test();
  end
endmodule
